// ==== logic/output_clock_rate_select_regs.svh ====
`ifndef OUTPUT_CLOCK_RATE_SELECT_REGS_SVH
`define OUTPUT_CLOCK_RATE_SELECT_REGS_SVH

// Register byte offsets on the APB.
`define ADDR_MAIN_PLL_CFG 8'h00
`define ADDR_AUX_PLL_CFG 8'h04
`define ADDR_OUT_SEL_A 8'h08
`define ADDR_OUT_SEL_B 8'h0c
`define ADDR_OUT_SEL_C 8'h10
`define ADDR_OUT_SEL_D 8'h14
`define ADDR_OUT_ALT_BANK 8'h18
`define ADDR_MISC_SIX 8'h1c
`define ADDR_MISC_SEVEN 8'h20
`define ADDR_MAIN_RATE_STAT 8'h24
`define ADDR_AUX_RATE_STAT 8'h28

// Field positions.
`define MAIN_CODE_LSB 0
`define FOLLOW_MAIN_BIT 3
`define MAIN_FOR_AUX_LSB 4
`define AUX_CODE_LSB 0
`define SEL_LO_LSB 0
`define SEL_HI_LSB 4
`define DIG1_FAMILY_BIT 0
`define DIG2_FAMILY_BIT 1
`define DIG2_ALT_BIT 2
`define DIG1_RATE_LSB 0
`define DIG2_RATE_LSB 2
`define AUX_ACTIVE_STAT_BIT 31

// Reset values: every output disabled and the auxiliary PLL powered down.
`define MAIN_PLL_CFG_RST 7'h00
`define AUX_PLL_CFG_RST 4'h0
`define OUT_SEL_RST 4'h0
`define OUT_ALT_BANK_RST 7'h00
`define MISC_SIX_RST 3'h0
`define MISC_SEVEN_RST 4'h0

// Rates in kHz.
`define KHZ_311040 20'h4bf00
`define KHZ_98304 20'h18000
`define KHZ_131072 20'h20000
`define KHZ_148224 20'h24300
`define KHZ_98816 20'h18200
`define KHZ_100992 20'h18a80
`define KHZ_250000 20'h3d090
`define KHZ_274944 20'h43200
`define KHZ_178944 20'h2bb00
`define KHZ_122880 20'h1e000
`define KHZ_160000 20'h27100
`define KHZ_104000 20'h19640
`define KHZ_312500 20'h4c4b4
`define KHZ_2048 20'h00800
`define KHZ_1544 20'h00608
`define KHZ_6312 20'h018a8
`define KHZ_10000 20'h02710
`define KHZ_19440 20'h04bf0
`define KHZ_38880 20'h097e0

`endif

// ==== logic/output_clock_rate_select_pkg.sv ====
package output_clock_rate_select_pkg;

  localparam int unsigned NUM_OUTPUTS = 7;

  // Where an output clock takes its edges from.
  typedef enum logic [3:0] {
    SRC_OFF,
    SRC_LOW,
    SRC_2K,
    SRC_8K,
    SRC_DIG1,
    SRC_DIG2,
    SRC_MAIN,
    SRC_SECOND,
    SRC_AUX,
    SRC_AUX_REF
  } source_t;

  typedef struct packed {
    source_t src;
    logic [6:0] div;
  } route_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } apb_rsp_t;

  typedef struct packed {
    logic [19:0] main_khz;
    logic [19:0] second_khz;
    logic [19:0] aux_khz;
    logic aux_active;
    logic [19:0] dig1_khz;
    logic [19:0] dig2_khz;
  } pll_cfg_t;

endpackage

// ==== logic/output_route_decode.sv ====
`timescale 1ns/1ps
`include "output_clock_rate_select_regs.svh"

module output_route_decode
  import output_clock_rate_select_pkg::*;
#(
  parameter int unsigned INDEX = 0
) (
  // Select inputs.
  input wire logic alt_i,
  input wire logic [3:0] code_i,
  input wire logic aux_active_i,
  // Decoded route.
  output route_t route_o
);

  // Outputs 0-2, 3-4 and 5-6 share the alternate bank layout, except output 0 at codes 5 and 6.
  localparam int unsigned GRP = (INDEX < 3) ? 0 : ((INDEX < 5) ? 1 : 2);

  route_t raw;

  // Packs a source and a ratio; a typed result keeps the conditional table rows legal and short.
  function automatic route_t rt(input source_t s, input logic [6:0] d);
    rt = '{src: s, div: d};
  endfunction

  // Select code to source and divide ratio; each output group and outputs 0, 5 and 6 have their own slight variants.
  always_comb begin
    raw = '{src: SRC_OFF, div: 7'h01};
    if (!alt_i) begin
      unique case (code_i)
        4'h0: raw.src = SRC_OFF;
        4'h1: raw.src = SRC_2K;
        4'h2: raw.src = SRC_8K;
        4'h3: raw = (INDEX == 5) ? rt(SRC_MAIN, 7'h02) : rt(SRC_DIG2, 7'h01);
        4'h4: raw = (INDEX == 6) ? rt(SRC_MAIN, 7'h02) : rt(SRC_DIG1, 7'h01);
        4'h5: raw = (INDEX == 5) ? rt(SRC_MAIN, 7'h01) : rt(SRC_MAIN, 7'h30);
        4'h6: raw = '{SRC_MAIN, 7'h10};
        4'h7: raw = '{SRC_MAIN, 7'h0c};
        4'h8: raw = '{SRC_MAIN, 7'h08};
        4'h9: raw = '{SRC_MAIN, 7'h06};
        4'ha: raw = '{SRC_MAIN, 7'h04};
        4'hb: raw = (GRP == 1) ? rt(SRC_AUX, 7'h02) : rt(SRC_AUX, 7'h40);
        4'hc: raw = '{SRC_AUX, 7'h30};
        4'hd: raw = '{SRC_AUX, 7'h10};
        4'he: raw = '{SRC_AUX, 7'h08};
        4'hf: raw = '{SRC_AUX, 7'h04};
      endcase
    end else begin
      unique case (code_i)
        4'h1: raw = (GRP == 0) ? rt(SRC_MAIN, 7'h40) : ((GRP == 1) ? rt(SRC_MAIN, 7'h02) : rt(SRC_AUX, 7'h05));
        4'h2: raw = (GRP == 0) ? rt(SRC_AUX, 7'h14) : ((GRP == 1) ? rt(SRC_MAIN, 7'h01) : rt(SRC_AUX, 7'h02));
        4'h3: raw = (GRP == 0) ? rt(SRC_AUX, 7'h0c) : ((GRP == 1) ? rt(SRC_AUX, 7'h0a) : rt(SRC_AUX, 7'h01));
        4'h4: raw = (GRP == 0) ? rt(SRC_AUX, 7'h0a) : ((GRP == 1) ? rt(SRC_SECOND, 7'h0a) : rt(SRC_SECOND, 7'h05));
        4'h5: raw = (INDEX == 0) ? rt(SRC_SECOND, 7'h0a) : ((GRP == 0) ? rt(SRC_AUX, 7'h05) : rt(SRC_SECOND, 7'h02));
        4'h6: raw = (INDEX == 0) ? rt(SRC_SECOND, 7'h05) : ((GRP == 0) ? rt(SRC_AUX, 7'h02) : rt(SRC_SECOND, 7'h01));
        4'h7: raw.src = SRC_AUX_REF;
        default: raw.src = SRC_OFF; // Codes 0 and 8-15 leave the output disabled.
      endcase
    end
  end

  // A powered-down auxiliary PLL holds every output it feeds low.
  always_comb begin
    route_o = raw;
    if (raw.src == SRC_AUX && !aux_active_i) begin
      route_o = '{SRC_LOW, 7'h01}; // RL14
    end
  end

endmodule

// ==== logic/output_clock_rate_select.sv ====
`timescale 1ns/1ps
`include "output_clock_rate_select_regs.svh"

// Overview of operation
// RL1: Software picks auxiliary PLL independent or follow-main.
// RL2: Each analog PLL holds one rate code only.
// RL3: Software usually sets main PLL to 311.04 MHz.
// RL4: Main PLL three-bit code decodes to its rate.
// RL5: Software sets main PLL code for outputs.
// RL6: Software sets auxiliary PLL code for outputs.
// RL7: Follow-main also needs the main-rate-for-aux field.
// RL8: Software writes per-output select codes and bank bits.
// RL9: Software configures PLLs before the output selects.
// RL10: Second main PLL fixed at 312.5 MHz.
// RL11: Digital synthesizer one rate from code and family.
// RL12: Digital synthesizer two adds alternate rate set.
// RL13: Output dividers offer the listed ratios only.
// RL14: Idle auxiliary PLL powers down, its outputs low.
// RL15: Each output has its own select code.

module output_clock_rate_select
  import output_clock_rate_select_pkg::*;
(
  // Clock, reset and enable.
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Register bus.
  input wire apb_req_t apb_i,
  output apb_rsp_t apb_o,
  // Decoded clock plan.
  output pll_cfg_t pll_o,
  output route_t [NUM_OUTPUTS-1:0] route_o
);

  // Configuration registers.
  logic [6:0] main_pll_config_reg;
  logic [3:0] aux_pll_config_reg;
  logic [NUM_OUTPUTS-1:0][3:0] output_rate_select;
  logic [NUM_OUTPUTS-1:0] output_alt_bank_reg;
  logic [2:0] misc_config_reg_six;
  logic [3:0] misc_config_reg_seven;
  logic [6:0] next_main_pll_config_reg;
  logic [3:0] next_aux_pll_config_reg;
  logic [NUM_OUTPUTS-1:0][3:0] next_output_rate_select;
  logic [NUM_OUTPUTS-1:0] next_output_alt_bank_reg;
  logic [2:0] next_misc_config_reg_six;
  logic [3:0] next_misc_config_reg_seven;
  apb_rsp_t next_apb;
  pll_cfg_t next_pll;
  route_t [NUM_OUTPUTS-1:0] next_route;

  // Named views of the fields.
  logic [2:0] main_apll_rate_code;
  logic aux_apll_follow_main;
  logic [2:0] main_rate_for_aux_code;
  logic [3:0] aux_apll_rate_code;
  logic digital_one_family_bit;
  logic digital_two_family_bit;
  logic digital_two_alt_bit;
  logic [1:0] digital_one_rate_code;
  logic [1:0] digital_two_rate_code;
  logic aux_active;
  logic [31:0] rdata;
  logic hit;

  assign main_apll_rate_code = main_pll_config_reg[`MAIN_CODE_LSB +: 3];
  assign aux_apll_follow_main = main_pll_config_reg[`FOLLOW_MAIN_BIT];
  assign main_rate_for_aux_code = main_pll_config_reg[`MAIN_FOR_AUX_LSB +: 3];
  assign aux_apll_rate_code = aux_pll_config_reg[`AUX_CODE_LSB +: 4];
  assign digital_one_family_bit = misc_config_reg_six[`DIG1_FAMILY_BIT];
  assign digital_two_family_bit = misc_config_reg_six[`DIG2_FAMILY_BIT];
  assign digital_two_alt_bit = misc_config_reg_six[`DIG2_ALT_BIT];
  assign digital_one_rate_code = misc_config_reg_seven[`DIG1_RATE_LSB +: 2];
  assign digital_two_rate_code = misc_config_reg_seven[`DIG2_RATE_LSB +: 2];

  // The auxiliary PLL sleeps only with a zero code and no follow-main request.
  assign aux_active = (aux_apll_rate_code != 4'h0) || aux_apll_follow_main; // RL14

  // Main PLL rate; codes 0 and 1 both give the SONET rate.
  function automatic logic [19:0] main_rate(input logic [2:0] code);
    unique case (code)
      3'h0, 3'h1: main_rate = `KHZ_311040;
      3'h2: main_rate = `KHZ_98304;
      3'h3: main_rate = `KHZ_131072;
      3'h4: main_rate = `KHZ_148224;
      3'h5: main_rate = `KHZ_98816;
      3'h6: main_rate = `KHZ_100992;
      3'h7: main_rate = `KHZ_250000;
    endcase
  endfunction

  // Auxiliary PLL rate when it runs on its own; unlisted codes read as zero.
  function automatic logic [19:0] aux_own_rate(input logic [3:0] code);
    unique case (code)
      4'h1: aux_own_rate = `KHZ_311040;
      4'h2: aux_own_rate = `KHZ_98304;
      4'h3: aux_own_rate = `KHZ_131072;
      4'h4: aux_own_rate = `KHZ_148224;
      4'h5: aux_own_rate = `KHZ_98816;
      4'h6: aux_own_rate = `KHZ_274944;
      4'h7: aux_own_rate = `KHZ_178944;
      4'h8: aux_own_rate = `KHZ_100992;
      4'h9: aux_own_rate = `KHZ_250000;
      4'ha: aux_own_rate = `KHZ_122880;
      4'hb: aux_own_rate = `KHZ_160000;
      4'hc: aux_own_rate = `KHZ_104000;
      default: aux_own_rate = 20'h00000;
    endcase
  endfunction

  // Auxiliary PLL rate while it follows the main loop; codes 3 and 5 are unlisted.
  function automatic logic [19:0] aux_follow_rate(input logic [2:0] code);
    unique case (code)
      3'h0: aux_follow_rate = `KHZ_98304;
      3'h1: aux_follow_rate = `KHZ_250000;
      3'h2: aux_follow_rate = `KHZ_131072;
      3'h4: aux_follow_rate = `KHZ_148224;
      3'h6: aux_follow_rate = `KHZ_98816;
      3'h7: aux_follow_rate = `KHZ_100992;
      default: aux_follow_rate = 20'h00000;
    endcase
  endfunction

  // E1 or DS1 family base rate doubled per code step.
  function automatic logic [19:0] dig_base_rate(input logic family, input logic [1:0] code);
    dig_base_rate = (family ? `KHZ_1544 : `KHZ_2048) << code;
  endfunction

  // Clock plan, registered so every output comes from a flip-flop.
  always_comb begin
    next_pll.main_khz = main_rate(main_apll_rate_code); // RL4 RL2
    next_pll.second_khz = `KHZ_312500; // RL10
    next_pll.aux_active = aux_active; // RL14
    if (!aux_active) begin
      next_pll.aux_khz = 20'h00000;
    end else if (aux_apll_follow_main) begin
      next_pll.aux_khz = aux_follow_rate(main_rate_for_aux_code);
    end else begin
      next_pll.aux_khz = aux_own_rate(aux_apll_rate_code); // RL2
    end
    next_pll.dig1_khz = dig_base_rate(digital_one_family_bit, digital_one_rate_code); // RL11
    next_pll.dig2_khz = dig_base_rate(digital_two_family_bit, digital_two_rate_code); // RL12
    if (digital_two_alt_bit) begin
      unique case ({digital_two_rate_code, digital_two_family_bit})
        3'b000: next_pll.dig2_khz = `KHZ_6312; // RL12
        3'b100: next_pll.dig2_khz = `KHZ_10000;
        3'b001: next_pll.dig2_khz = `KHZ_19440;
        3'b011: next_pll.dig2_khz = `KHZ_38880;
        default: next_pll.dig2_khz = 20'h00000;
      endcase
    end
  end

  // One decoder per output; the divider set is fixed by the decode table.
  for (genvar n = 0; n < NUM_OUTPUTS; n++) begin : g_out
    output_route_decode #(
      .INDEX(n)
    ) output_route_decode_inst (
      .alt_i(output_alt_bank_reg[n]),
      .code_i(output_rate_select[n]), // RL15 RL13
      .aux_active_i(aux_active),
      .route_o(next_route[n])
    );
  end

  // Read mux; status words show the decoded rates, not the raw codes.
  always_comb begin
    rdata = 32'h00000000;
    hit = 1'b1;
    unique case (apb_i.paddr)
      `ADDR_MAIN_PLL_CFG: rdata[6:0] = main_pll_config_reg;
      `ADDR_AUX_PLL_CFG: rdata[3:0] = aux_pll_config_reg;
      `ADDR_OUT_SEL_A: rdata[7:0] = {output_rate_select[1], output_rate_select[0]};
      `ADDR_OUT_SEL_B: rdata[7:0] = {output_rate_select[3], output_rate_select[2]};
      `ADDR_OUT_SEL_C: rdata[7:0] = {output_rate_select[5], output_rate_select[4]};
      `ADDR_OUT_SEL_D: rdata[3:0] = output_rate_select[6];
      `ADDR_OUT_ALT_BANK: rdata[6:0] = output_alt_bank_reg;
      `ADDR_MISC_SIX: rdata[2:0] = misc_config_reg_six;
      `ADDR_MISC_SEVEN: rdata[3:0] = misc_config_reg_seven;
      `ADDR_MAIN_RATE_STAT: rdata[19:0] = pll_o.main_khz;
      `ADDR_AUX_RATE_STAT: rdata = {pll_o.aux_active, 11'h000, pll_o.aux_khz};
      default: hit = 1'b0;
    endcase
  end

  // APB slave with one wait state; writes land at the completing edge only.
  always_comb begin
    next_main_pll_config_reg = main_pll_config_reg;
    next_aux_pll_config_reg = aux_pll_config_reg;
    next_output_rate_select = output_rate_select;
    next_output_alt_bank_reg = output_alt_bank_reg;
    next_misc_config_reg_six = misc_config_reg_six;
    next_misc_config_reg_seven = misc_config_reg_seven;
    next_apb = '0;
    if (apb_i.psel && apb_i.penable && !apb_o.pready) begin
      next_apb.pready = 1'b1;
      next_apb.prdata = apb_i.pwrite ? 32'h00000000 : rdata;
      // Status words are read-only, so a write to them is flagged too.
      next_apb.pslverr = !hit || (apb_i.pwrite &&
        (apb_i.paddr == `ADDR_MAIN_RATE_STAT || apb_i.paddr == `ADDR_AUX_RATE_STAT));
    end
    if (apb_i.psel && apb_i.penable && apb_o.pready && apb_i.pwrite) begin
      unique case (apb_i.paddr)
        `ADDR_MAIN_PLL_CFG: next_main_pll_config_reg = apb_i.pwdata[6:0]; // RL5 RL7 RL1
        `ADDR_AUX_PLL_CFG: next_aux_pll_config_reg = apb_i.pwdata[3:0]; // RL6
        `ADDR_OUT_SEL_A: begin
          next_output_rate_select[0] = apb_i.pwdata[`SEL_LO_LSB +: 4]; // RL8
          next_output_rate_select[1] = apb_i.pwdata[`SEL_HI_LSB +: 4];
        end
        `ADDR_OUT_SEL_B: begin
          next_output_rate_select[2] = apb_i.pwdata[`SEL_LO_LSB +: 4];
          next_output_rate_select[3] = apb_i.pwdata[`SEL_HI_LSB +: 4];
        end
        `ADDR_OUT_SEL_C: begin
          next_output_rate_select[4] = apb_i.pwdata[`SEL_LO_LSB +: 4];
          next_output_rate_select[5] = apb_i.pwdata[`SEL_HI_LSB +: 4];
        end
        `ADDR_OUT_SEL_D: next_output_rate_select[6] = apb_i.pwdata[`SEL_LO_LSB +: 4];
        `ADDR_OUT_ALT_BANK: next_output_alt_bank_reg = apb_i.pwdata[6:0]; // RL8
        `ADDR_MISC_SIX: next_misc_config_reg_six = apb_i.pwdata[2:0];
        `ADDR_MISC_SEVEN: next_misc_config_reg_seven = apb_i.pwdata[3:0];
        default: ;
      endcase
    end
  end

  // Order of programming is left to software; the plan simply tracks the registers.
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      main_pll_config_reg <= `MAIN_PLL_CFG_RST;
      aux_pll_config_reg <= `AUX_PLL_CFG_RST;
      output_rate_select <= {NUM_OUTPUTS{`OUT_SEL_RST}};
      output_alt_bank_reg <= `OUT_ALT_BANK_RST;
      misc_config_reg_six <= `MISC_SIX_RST;
      misc_config_reg_seven <= `MISC_SEVEN_RST;
      apb_o <= '0;
      pll_o <= '0;
      route_o <= '0;
    end else if (ce_i) begin
      main_pll_config_reg <= next_main_pll_config_reg;
      aux_pll_config_reg <= next_aux_pll_config_reg;
      output_rate_select <= next_output_rate_select;
      output_alt_bank_reg <= next_output_alt_bank_reg;
      misc_config_reg_six <= next_misc_config_reg_six;
      misc_config_reg_seven <= next_misc_config_reg_seven;
      apb_o <= next_apb;
      pll_o <= next_pll;
      route_o <= next_route;
    end
  end

endmodule

// ==== verification/output_clock_rate_select_monitor.sv ====
`timescale 1ns/1ps
`include "output_clock_rate_select_regs.svh"

module output_clock_rate_select_monitor
  import output_clock_rate_select_pkg::*;
(
  // Clock, reset and enable.
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Bus and decoded plan.
  input wire apb_req_t apb_i,
  input wire apb_rsp_t apb_o,
  input wire pll_cfg_t pll_o,
  input wire route_t [NUM_OUTPUTS-1:0] route_o
);
  localparam logic [19:0] MAIN_T [8] = '{`KHZ_311040, `KHZ_311040, `KHZ_98304, `KHZ_131072,
    `KHZ_148224, `KHZ_98816, `KHZ_100992, `KHZ_250000};
  logic [1:0] up_cnt;
  logic [2:0] main_code;
  logic div_ok;
  logic aux_used;

  default clocking mon_cb @(posedge ref_clk_i);
  endclocking
  // A low enable stalls the whole block, so cycle-exact checks stand aside while it is low.
  default disable iff (!rst_n_i || !ce_i);

  // Plan outputs settle one edge after reset; checks on them wait for the count to reach two.
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      up_cnt <= 2'h0;
    end else if (ce_i && up_cnt != 2'h2) begin
      up_cnt <= up_cnt + 2'h1;
    end
    if (ce_i && apb_i.psel && apb_i.penable && apb_o.pready && apb_i.pwrite && apb_i.paddr == `ADDR_MAIN_PLL_CFG) begin
      main_code <= apb_i.pwdata[2:0];
    end
  end

  // Divider legality and use of the auxiliary PLL over all outputs.
  always_comb begin
    div_ok = 1'b1;
    aux_used = 1'b0;
    for (int n = 0; n < NUM_OUTPUTS; n++) begin
      if (route_o[n].src inside {SRC_MAIN, SRC_SECOND, SRC_AUX} && !(route_o[n].div inside {7'h01, 7'h02,
          7'h04, 7'h05, 7'h06, 7'h08, 7'h0a, 7'h0c, 7'h10, 7'h14, 7'h30, 7'h40})) begin
        div_ok = 1'b0;
      end
      if (route_o[n].src == SRC_AUX) begin
        aux_used = 1'b1;
      end
    end
  end

  sequence s_wr(logic [7:0] a);
    apb_i.psel && apb_i.penable && apb_o.pready && apb_i.pwrite && apb_i.paddr == a;
  endsequence
  sequence s_access;
    apb_i.psel && apb_i.penable && !apb_o.pready ##1 apb_o.pready;
  endsequence

  property p_pready_lag;
    apb_i.psel && !apb_i.penable |=> s_access;
  endproperty
  a_pready_lag: assert property (p_pready_lag) else $error("Answer not one wait state after access");
  property p_pready_pulse;
    apb_o.pready |=> !apb_o.pready;
  endproperty
  a_pready_pulse: assert property (p_pready_pulse) else $error("Ready held beyond one cycle");
  property p_unmapped;
    apb_o.pready && apb_i.paddr > `ADDR_AUX_RATE_STAT |-> apb_o.pslverr && apb_o.prdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("Unmapped access not refused");
  property p_ro_write;
    s_wr(`ADDR_MAIN_RATE_STAT) |-> apb_o.pslverr;
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("Write to status not refused");
  property p_main_rate;
    s_wr(`ADDR_MAIN_PLL_CFG) |-> ##2 pll_o.main_khz == MAIN_T[main_code];
  endproperty
  a_main_rate: assert property (p_main_rate) else $error("Main PLL rate wrong for code");
  property p_second;
    up_cnt == 2'h2 |-> pll_o.second_khz == `KHZ_312500;
  endproperty
  a_second: assert property (p_second) else $error("Second main PLL rate not fixed");
  property p_aux_down;
    up_cnt == 2'h2 && !pll_o.aux_active |-> pll_o.aux_khz == 20'h0 && !aux_used;
  endproperty
  a_aux_down: assert property (p_aux_down) else $error("Powered-down auxiliary PLL still used");
  property p_aux_wake;
    s_wr(`ADDR_AUX_PLL_CFG) ##0 apb_i.pwdata[3:0] != 4'h0 |-> ##2 pll_o.aux_active;
  endproperty
  a_aux_wake: assert property (p_aux_wake) else $error("Auxiliary PLL not powered up");
  property p_div_legal;
    up_cnt == 2'h2 |-> div_ok;
  endproperty
  a_div_legal: assert property (p_div_legal) else $error("Divider ratio not offered");
  property p_out7_off;
    s_wr(`ADDR_OUT_SEL_D) ##0 apb_i.pwdata[3:0] == 4'h0 |-> ##2 route_o[6].src == SRC_OFF;
  endproperty
  a_out7_off: assert property (p_out7_off) else $error("Seventh output not disabled");
endmodule

bind output_clock_rate_select output_clock_rate_select_monitor output_clock_rate_select_monitor_inst (
  .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .apb_i(apb_i), .apb_o(apb_o), .pll_o(pll_o),
  .route_o(route_o)
);

// ==== verification/output_clock_rate_select_tb.sv ====
`timescale 1ns/1ps
`include "output_clock_rate_select_regs.svh"

module output_clock_rate_select_tb
  import output_clock_rate_select_pkg::*;
;
  localparam logic [19:0] MAIN_T [8] = '{`KHZ_311040, `KHZ_311040, `KHZ_98304, `KHZ_131072,
    `KHZ_148224, `KHZ_98816, `KHZ_100992, `KHZ_250000};
  localparam logic [19:0] DIG_T [8] = '{`KHZ_2048, 20'h01000, 20'h02000, 20'h04000,
    `KHZ_1544, 20'h00c10, 20'h01820, 20'h03040};
  localparam logic [19:0] ALT_T [8] = '{`KHZ_6312, 20'h0, `KHZ_10000, 20'h0, `KHZ_19440, `KHZ_38880, 20'h0, 20'h0};
  logic ref_clk_i;
  logic rst_n_i;
  logic ce_i;
  apb_req_t req;
  apb_rsp_t rsp;
  pll_cfg_t pll;
  route_t [NUM_OUTPUTS-1:0] route;
  logic [32:0] exp_q[$];
  int num_errors;
  int n_tests;
  int seed;

  output_clock_rate_select output_clock_rate_select_inst (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .apb_i(req), .apb_o(rsp), .pll_o(pll),
    .route_o(route)
  );

  // Free-running 250 MHz clock.
  initial begin
    ref_clk_i = 1'b0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // The request is held until ready is seen; one idle edge keeps drives apart.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
    int n;
    n = 0;
    exp_q.push_back(e);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge ref_clk_i);
    req.penable <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (rsp.pready !== 1'b1 && n < 16);
    if (rsp.pready !== 1'b1) begin
      num_errors++;
      end_of_test();
    end
    req <= '0;
    @(posedge ref_clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, {1'b0, e});
  endtask

  // Plan outputs trail a register write by one edge; two edges leave margin.
  task automatic settle();
    repeat (2) @(posedge ref_clk_i);
  endtask

  function automatic route_t exp_route(input logic [4:0] ac, input int n);
    case (ac)
      5'h01: return route_t'{SRC_2K, 7'h01};
      5'h02: return route_t'{SRC_8K, 7'h01};
      5'h03: return n == 5 ? route_t'{SRC_MAIN, 7'h02} : route_t'{SRC_DIG2, 7'h01};
      5'h17: return route_t'{SRC_AUX_REF, 7'h01};
      5'h04: return n == 6 ? route_t'{SRC_MAIN, 7'h02} : route_t'{SRC_DIG1, 7'h01};
      5'h05: return route_t'{SRC_MAIN, n == 5 ? 7'h01 : 7'h30};
      5'h0e: return route_t'{SRC_AUX, 7'h08};
      5'h14: return n < 3 ? route_t'{SRC_AUX, 7'h0a} : route_t'{SRC_SECOND, n < 5 ? 7'h0a : 7'h05};
      default: return route_t'{SRC_OFF, 7'h01};
    endcase
  endfunction

  // Every answer retires the oldest noted result; an answer nobody asked for fails.
  always @(posedge ref_clk_i) begin
    if (rst_n_i === 1'b1 && rsp.pready === 1'b1) begin
      chk(64'({rsp.pslverr, rsp.prdata}), exp_q.size() > 0 ? 64'(exp_q.pop_front()) : '1);
    end
  end

  // Main sequence.
  initial begin
    logic [4:0] acs [10];
    route_t er;
    acs = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h0e, 5'h14, 5'h17, 5'h1e, 5'h00};
    seed = 45;
    num_errors = 0;
    n_tests = 0;
    rst_n_i = 1'b0;
    ce_i = 1'b1;
    req = '0;
    repeat (3) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    chk(64'(pll.second_khz), 64'(`KHZ_312500));
    chk(64'({pll.main_khz, pll.dig1_khz, pll.dig2_khz}), 64'({`KHZ_311040, `KHZ_2048, `KHZ_2048}));
    chk(64'({pll.aux_active, pll.aux_khz}), 64'h0);
    for (int a = 0; a <= 32; a += 4) begin
      rd(8'(a), 32'h0);
    end
    rd(`ADDR_MAIN_RATE_STAT, 32'(`KHZ_311040));
    for (int c = 0; c < 8; c++) begin
      wr(`ADDR_MAIN_PLL_CFG, ($random(seed) & 32'hffffff80) | 32'(c));
      settle();
      chk(64'(pll.main_khz), 64'(MAIN_T[c]));
      rd(`ADDR_MAIN_RATE_STAT, 32'(MAIN_T[c]));
      rd(`ADDR_MAIN_PLL_CFG, 32'(c));
    end
    // A low enable must hold a pending write and the plan; a block that ignored it would update early.
    ce_i <= 1'b0;
    fork
      wr(`ADDR_MAIN_PLL_CFG, 32'h2);
      begin
        repeat (6) @(posedge ref_clk_i);
        chk(64'({rsp.pready, pll.main_khz}), 64'(`KHZ_250000));
        ce_i <= 1'b1;
      end
    join
    settle();
    chk(64'(pll.main_khz), 64'(`KHZ_98304));
    for (int i = 0; i < 32; i++) begin
      wr(`ADDR_MISC_SIX, 32'(i[4:2]));
      wr(`ADDR_MISC_SEVEN, ($random(seed) & 32'hfffffff0) | 32'({i[1:0], i[1:0]}));
      settle();
      chk(64'(pll.dig1_khz), 64'(DIG_T[{i[2], i[1:0]}]));
      chk(64'(pll.dig2_khz), 64'(i[4] ? ALT_T[{i[3], i[1:0]}] : DIG_T[{i[3], i[1:0]}]));
    end
    wr(`ADDR_OUT_SEL_A, 32'h0000000f);
    settle();
    chk(64'(route[0].src), 64'(SRC_LOW));
    wr(`ADDR_AUX_PLL_CFG, 32'h1);
    settle();
    chk(64'(route[0]), 64'({SRC_AUX, 7'h04}));
    rd(`ADDR_AUX_RATE_STAT, {1'b1, 11'h0, `KHZ_311040});
    wr(`ADDR_AUX_PLL_CFG, 32'h0);
    wr(`ADDR_MAIN_PLL_CFG, 32'h18);
    rd(`ADDR_AUX_RATE_STAT, {1'b1, 11'h0, `KHZ_250000});
    foreach (acs[k]) begin
      wr(`ADDR_OUT_ALT_BANK, acs[k][4] ? 32'h7f : 32'h0);
      for (int r = 0; r < 4; r++) begin
        wr(8'(`ADDR_OUT_SEL_A + 4 * r), {24'h0, acs[k][3:0], acs[k][3:0]});
      end
      settle();
      for (int n = 0; n < NUM_OUTPUTS; n++) begin
        er = exp_route(acs[k], n);
        chk(64'(route[n]), 64'(er));
      end
    end
    apb(1'b0, 8'h2c, 32'h0, {1'b1, 32'h0});
    apb(1'b1, 8'h2c, $random(seed), {1'b1, 32'h0});
    apb(1'b1, `ADDR_MAIN_RATE_STAT, $random(seed), {1'b1, 32'h0});
    rd(`ADDR_MAIN_RATE_STAT, 32'(`KHZ_311040));
    end_of_test();
  end
endmodule
